// *** src/upi_pkg.sv ***
// constants and carrier types for the three-channel serial pin block
package upi_pkg;
	localparam int          UPI_CHANNELS      = 3;
	localparam int          UPI_FLOW_CHANNELS = 2;
	localparam int          UPI_DATA_BITS     = 8;
	localparam int          UPI_DIV_W         = 16;
	localparam int          UPI_BUF_DEPTH     = 2;
	localparam logic [15:0] UPI_BAUD_HALF_DEF = 16'h0022;
	localparam logic [15:0] UPI_DIV_ZERO      = 16'h0000;
	localparam logic [3:0]  UPI_SUB_ZERO      = 4'h0;
	localparam logic [3:0]  UPI_SUB_LAST      = 4'hF;
	localparam logic [3:0]  UPI_SUB_MID       = 4'h7;
	localparam logic [2:0]  UPI_BIT_ZERO      = 3'h0;
	localparam logic [2:0]  UPI_BIT_LAST      = 3'h7;
	localparam logic [1:0]  UPI_CNT_EMPTY     = 2'h0;
	localparam logic [1:0]  UPI_CNT_ONE       = 2'h1;
	localparam logic [1:0]  UPI_CNT_FULL      = 2'h2;
	localparam logic        UPI_MARK          = 1'b1;
	localparam logic        UPI_SPACE         = 1'b0;

	// frame phase shared by transmitter and receiver
	typedef enum logic [1:0]
	{
		UPI_IDLE  = 2'b00,
		UPI_START = 2'b01,
		UPI_DATA  = 2'b10,
		UPI_STOP  = 2'b11
	} upi_phase_type;

	// per-channel control levels from the owning logic
	typedef struct packed
	{
		logic tx_en;
		logic rx_en;
		logic loopback;
		logic cts_en;
		logic rts_fifo_mode;
		logic sleep_req;
	} upi_cfg_type;

	// per-channel state shown to the owning logic
	typedef struct packed
	{
		logic frame_err;
		logic overrun;
		logic clk_running;
		logic tx_busy;
	} upi_stat_type;
endpackage

// *** src/upi_serial.sv ***
// three serial channels with pin-level framing and wake-up, flow control on channels zero and one only
// Function
// (RULE1) three channels; only zero, one have handshake
// (RULE2) transmit line idles high when disabled/idle/loopback; a frame under way when tx_en drops still runs to its stop bit
// (RULE3) transmit lsb first, change on falling edge
// (RULE4) receive sampled on rising edge, lsb first
// (RULE5) receive line change restarts stopped clock
// (RULE6) start sending only while clear-to-send low
// (RULE7) request-to-send automatic or by receive fill
// (RULE8) one low start, data, high stop
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// two-entry buffer, valid and ready on both sides
module upi_buf #(parameter int W = 8)
(
	input  wire logic         clk_sys_in,
	input  wire logic         srst_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [1:0]        level_out
);
	import upi_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0]   cnt;
	} upi_buf_state_type;

	upi_buf_state_type s_ff;
	upi_buf_state_type nxt_s;
	logic              push;
	logic              pop;

	assign in_ready_out  = (s_ff.cnt != UPI_CNT_FULL);
	assign out_valid_out = (s_ff.cnt != UPI_CNT_EMPTY);
	assign out_data_out  = s_ff.d0;
	assign level_out     = s_ff.cnt;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// head in d0; a pop shifts d1 down so order holds
	always_comb
	begin
		nxt_s = s_ff;
		if (pop)
			nxt_s.d0 = s_ff.d1;
		if (push)
		begin
			if (s_ff.cnt == UPI_CNT_EMPTY || (pop && s_ff.cnt == UPI_CNT_ONE))
				nxt_s.d0 = in_data_in;
			else
				nxt_s.d1 = in_data_in;
		end
		if (push && !pop)
			nxt_s.cnt = s_ff.cnt + UPI_CNT_ONE;
		else if (pop && !push)
			nxt_s.cnt = s_ff.cnt - UPI_CNT_ONE;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// one serial channel: divider, transmitter, receiver, handshake
module upi_channel #(
	parameter logic [15:0] BAUD_HALF = upi_pkg::UPI_BAUD_HALF_DEF,
	parameter bit          HAS_FLOW  = 1'b1
)
(
	input  wire logic               clk_sys_in,
	input  wire logic               srst_in,
	input  wire upi_pkg::upi_cfg_type cfg_in,
	input  wire logic [7:0]         tx_data_in,
	input  wire logic               tx_valid_in,
	output logic                    tx_ready_out,
	output logic [7:0]              rx_data_out,
	output logic                    rx_valid_out,
	input  wire logic               rx_ready_in,
	output logic                    serial_tx_out,
	input  wire logic               serial_rx_in,
	input  wire logic               clear_to_send_n_in,
	output logic                    request_to_send_n_out,
	output upi_pkg::upi_stat_type   status_out
);
	import upi_pkg::*;

	typedef struct packed
	{
		logic          rx_s1;
		logic          rx_s2;
		logic          rx_s3;
		logic          cts_s1;
		logic          cts_s2;
		logic [15:0]   div;
		logic          sclk;
		logic          stopped;
		logic          sleep_d;
		upi_phase_type tx_ph;
		logic [3:0]    tx_sub;
		logic [2:0]    tx_bit;
		logic [7:0]    tx_sh;
		logic          tx_line;
		logic          tx_pin;
		upi_phase_type rx_ph;
		logic [3:0]    rx_sub;
		logic [2:0]    rx_bit;
		logic [7:0]    rx_sh;
		logic          rx_push;
		logic          frame_err;
		logic          overrun;
		logic          rts_n;
	} upi_ch_state_type;

	upi_ch_state_type s_ff;
	upi_ch_state_type nxt_s;
	logic [7:0]       txb_data;
	logic             txb_valid;
	logic             txb_pop;
	logic             rxb_ready;
	logic [1:0]       rxb_level;
	logic             tick;
	logic             rise;
	logic             fall;
	logic             rx_line;
	logic             cts_ok;
	logic             rx_edge;

	// transmit words wait here so the source sees back-pressure
	upi_buf #(.W(UPI_DATA_BITS)) u_txb
	(
		.clk_sys_in    (clk_sys_in),
		.srst_in       (srst_in),
		.in_data_in    (tx_data_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (txb_data),
		.out_valid_out (txb_valid),
		.out_ready_in  (txb_pop),
		.level_out     ()
	);

	// received words wait here when the reader stalls
	upi_buf #(.W(UPI_DATA_BITS)) u_rxb
	(
		.clk_sys_in    (clk_sys_in),
		.srst_in       (srst_in),
		.in_data_in    (s_ff.rx_sh),
		.in_valid_in   (s_ff.rx_push),
		.in_ready_out  (rxb_ready),
		.out_data_out  (rx_data_out),
		.out_valid_out (rx_valid_out),
		.out_ready_in  (rx_ready_in),
		.level_out     (rxb_level)
	);

	// serial clock edges; none while the channel clock is stopped
	assign tick    = !s_ff.stopped && (s_ff.div == BAUD_HALF - 16'h0001);
	assign rise    = tick && !s_ff.sclk;
	assign fall    = tick && s_ff.sclk;
	assign rx_line = cfg_in.loopback ? s_ff.tx_line : s_ff.rx_s2;
	assign rx_edge = s_ff.rx_s2 != s_ff.rx_s3;
	// handshake input only exists on flow channels
	assign cts_ok  = !cfg_in.cts_en || !HAS_FLOW || (s_ff.cts_s2 == 1'b0);
	assign txb_pop = fall && s_ff.tx_ph == UPI_IDLE && cfg_in.tx_en
		&& txb_valid && cts_ok;

	assign serial_tx_out         = s_ff.tx_pin;
	assign request_to_send_n_out = s_ff.rts_n;
	assign status_out = '{frame_err: s_ff.frame_err, overrun: s_ff.overrun,
		clk_running: !s_ff.stopped, tx_busy: s_ff.tx_ph != UPI_IDLE};

	always_comb
	begin
		nxt_s = s_ff;
		// pins pass two flops before any logic reads them
		nxt_s.rx_s1  = serial_rx_in;
		nxt_s.rx_s2  = s_ff.rx_s1;
		nxt_s.rx_s3  = s_ff.rx_s2;
		nxt_s.cts_s1 = clear_to_send_n_in;
		nxt_s.cts_s2 = s_ff.cts_s1;
		nxt_s.rx_push = 1'b0;
		nxt_s.sleep_d = cfg_in.sleep_req;
		// divider halts while stopped to save power
		if (s_ff.stopped || tick)
			nxt_s.div = UPI_DIV_ZERO;
		else
			nxt_s.div = s_ff.div + 16'h0001;
		if (tick)
			nxt_s.sclk = !s_ff.sclk;
		// (RULE5) wake on edge: a receive edge beats a new stop request
		if (rx_edge)
			nxt_s.stopped = 1'b0;
		else if (cfg_in.sleep_req && !s_ff.sleep_d)
			nxt_s.stopped = 1'b1;

		// (RULE3) transmitter moves only on falling edges
		if (fall)
		begin
			nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
			case (s_ff.tx_ph)
				UPI_IDLE:
				begin
					// (RULE6) cts gates only the start of a frame
					if (txb_pop)
					begin
						nxt_s.tx_sh   = txb_data;
						nxt_s.tx_ph   = UPI_START;
						nxt_s.tx_sub  = UPI_SUB_ZERO;
						// (RULE8) low start bit
						nxt_s.tx_line = UPI_SPACE;
					end
					else
					begin
						nxt_s.tx_sub  = UPI_SUB_ZERO;
						nxt_s.tx_line = UPI_MARK;
					end
				end
				UPI_START:
				begin
					if (s_ff.tx_sub == UPI_SUB_LAST)
					begin
						nxt_s.tx_ph   = UPI_DATA;
						nxt_s.tx_bit  = UPI_BIT_ZERO;
						nxt_s.tx_line = s_ff.tx_sh[0];
					end
				end
				UPI_DATA:
				begin
					// (RULE3) lsb first shift
					if (s_ff.tx_sub == UPI_SUB_LAST)
					begin
						nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
						if (s_ff.tx_bit == UPI_BIT_LAST)
						begin
							nxt_s.tx_ph   = UPI_STOP;
							nxt_s.tx_line = UPI_MARK;
						end
						else
						begin
							nxt_s.tx_bit  = s_ff.tx_bit + 3'h1;
							nxt_s.tx_line = s_ff.tx_sh[1];
						end
					end
				end
				UPI_STOP:
				begin
					// (RULE8) full stop bit before next start
					if (s_ff.tx_sub == UPI_SUB_LAST)
						nxt_s.tx_ph = UPI_IDLE;
				end
				default:
					nxt_s.tx_ph = UPI_IDLE;
			endcase
		end
		// (RULE2) mark on the pin when idle, disabled between frames or looped back
		nxt_s.tx_pin = (cfg_in.loopback || nxt_s.tx_ph == UPI_IDLE)
			? UPI_MARK : nxt_s.tx_line;

		// (RULE4) receiver samples only on rising edges
		if (rise)
		begin
			nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
			case (s_ff.rx_ph)
				UPI_IDLE:
				begin
					nxt_s.rx_sub = UPI_SUB_ZERO;
					if (cfg_in.rx_en && rx_line == UPI_SPACE)
						nxt_s.rx_ph = UPI_START;
				end
				UPI_START:
				begin
					// recheck mid start bit to reject glitches
					if (s_ff.rx_sub == UPI_SUB_MID)
					begin
						nxt_s.rx_sub = UPI_SUB_ZERO;
						nxt_s.rx_bit = UPI_BIT_ZERO;
						nxt_s.rx_ph  = (rx_line == UPI_SPACE) ? UPI_DATA
							: UPI_IDLE;
					end
				end
				UPI_DATA:
				begin
					// (RULE4) lsb arrives first, shift in from top
					if (s_ff.rx_sub == UPI_SUB_LAST)
					begin
						nxt_s.rx_sh = {rx_line, s_ff.rx_sh[7:1]};
						if (s_ff.rx_bit == UPI_BIT_LAST)
							nxt_s.rx_ph = UPI_STOP;
						else
							nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
					end
				end
				UPI_STOP:
				begin
					// (RULE8) stop must be high, else framing error
					if (s_ff.rx_sub == UPI_SUB_LAST)
					begin
						nxt_s.rx_ph = UPI_IDLE;
						if (rx_line == UPI_MARK)
						begin
							nxt_s.rx_push = 1'b1;
							nxt_s.overrun = s_ff.overrun || !rxb_ready;
						end
						else
							nxt_s.frame_err = 1'b1;
					end
				end
				default:
					nxt_s.rx_ph = UPI_IDLE;
			endcase
		end

		// (RULE7) fill-level mode or follow transmitter activity
		if (!HAS_FLOW)
			nxt_s.rts_n = 1'b1;
		else if (cfg_in.rts_fifo_mode)
			nxt_s.rts_n = (rxb_level == UPI_CNT_FULL);
		else
			nxt_s.rts_n = !(txb_valid || nxt_s.tx_ph != UPI_IDLE);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			s_ff         <= '0;
			s_ff.rx_s1   <= UPI_MARK;
			s_ff.rx_s2   <= UPI_MARK;
			s_ff.rx_s3   <= UPI_MARK;
			s_ff.cts_s1  <= 1'b1;
			s_ff.cts_s2  <= 1'b1;
			s_ff.tx_line <= UPI_MARK;
			s_ff.tx_pin  <= UPI_MARK;
			s_ff.rts_n   <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	AST_TX_IDLE_MARK: assert property ( // RULE2
		s_ff.tx_ph == UPI_IDLE |-> serial_tx_out == UPI_MARK)
		else $error("transmit line not high while idle");
	AST_LOOP_MARK: assert property ( // RULE2
		$past(cfg_in.loopback) |-> serial_tx_out == UPI_MARK)
		else $error("transmit line not high in loopback");
	AST_TX_ON_FALL: assert property ( // RULE3
		!$stable(s_ff.tx_line) |-> $past(fall))
		else $error("transmit bit changed off a falling edge");
	AST_RX_ON_RISE: assert property ( // RULE4
		s_ff.rx_push |-> $past(rise))
		else $error("receive word completed off a rising edge");
	AST_WAKE: assert property ( // RULE5
		s_ff.stopped && rx_edge |=> !s_ff.stopped)
		else $error("receive edge did not restart the clock");
	AST_CTS_GATE: assert property ( // RULE6
		HAS_FLOW && cfg_in.cts_en && s_ff.cts_s2 && s_ff.tx_ph == UPI_IDLE
		|=> s_ff.tx_ph == UPI_IDLE)
		else $error("frame started without clear-to-send");
	AST_RTS_FULL: assert property ( // RULE7
		HAS_FLOW && cfg_in.rts_fifo_mode && rxb_level == UPI_CNT_FULL
		|=> request_to_send_n_out)
		else $error("request-to-send held while receive buffer full");
	AST_START_LOW: assert property ( // RULE8
		s_ff.tx_ph == UPI_START && !cfg_in.loopback |=> $past(fall) ||
		serial_tx_out == UPI_SPACE)
		else $error("start bit not low on the pin");
	AST_STOP_HIGH: assert property ( // RULE8
		s_ff.tx_ph == UPI_STOP |-> s_ff.tx_line == UPI_MARK)
		else $error("stop bit not high");

	COV_TX_FRAME: cover property (
		s_ff.tx_ph == UPI_STOP ##1 s_ff.tx_ph == UPI_IDLE);
	COV_RX_WORD: cover property (s_ff.rx_push);
	COV_WAKE: cover property (s_ff.stopped ##1 !s_ff.stopped);
	COV_RX_STALL: cover property (rxb_level == UPI_CNT_FULL && !rx_ready_in);
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: three channels side by side
module upi_serial #(parameter logic [15:0] BAUD_HALF =
	upi_pkg::UPI_BAUD_HALF_DEF)
(
	input  wire logic                        clk_sys_in,
	input  wire logic                        srst_in,
	input  wire upi_pkg::upi_cfg_type [2:0]  cfg_in,
	input  wire logic [2:0][7:0]             tx_data_in,
	input  wire logic [2:0]                  tx_valid_in,
	output logic [2:0]                       tx_ready_out,
	output logic [2:0][7:0]                  rx_data_out,
	output logic [2:0]                       rx_valid_out,
	input  wire logic [2:0]                  rx_ready_in,
	output logic [2:0]                       serial_tx_out,
	input  wire logic [2:0]                  serial_rx_in,
	input  wire logic [1:0]                  clear_to_send_n_in,
	output logic [1:0]                       request_to_send_n_out,
	output upi_pkg::upi_stat_type [2:0]      status_out
);
	import upi_pkg::*;

	logic [2:0] cts_n;
	logic [2:0] rts_n;

	// (RULE1) three channels, handshake pins on the first two only
	assign cts_n                 = {1'b1, clear_to_send_n_in};
	assign request_to_send_n_out = rts_n[1:0];

	for (genvar ch = 0; ch < UPI_CHANNELS; ch++)
	begin : g_ch
		upi_channel #(
			.BAUD_HALF (BAUD_HALF),
			.HAS_FLOW  (ch < UPI_FLOW_CHANNELS)
		) u_ch
		(
			.clk_sys_in            (clk_sys_in),
			.srst_in               (srst_in),
			.cfg_in                (cfg_in[ch]),
			.tx_data_in            (tx_data_in[ch]),
			.tx_valid_in           (tx_valid_in[ch]),
			.tx_ready_out          (tx_ready_out[ch]),
			.rx_data_out           (rx_data_out[ch]),
			.rx_valid_out          (rx_valid_out[ch]),
			.rx_ready_in           (rx_ready_in[ch]),
			.serial_tx_out         (serial_tx_out[ch]),
			.serial_rx_in          (serial_rx_in[ch]),
			.clear_to_send_n_in    (cts_n[ch]),
			.request_to_send_n_out (rts_n[ch]),
			.status_out            (status_out[ch])
		);
	end
endmodule

// *** tb/test_upi_serial.sv ***
// self-checking bench for the three-channel serial pin block
`timescale 1ns/100ps

module test_upi_serial;
	import upi_pkg::*;
	localparam logic [15:0] HALF = 16'h0002;
	logic                   clk_sys_in;
	logic                   srst_in;
	upi_cfg_type [2:0]      cfg;
	logic [2:0][7:0]        tx_data;
	logic [2:0]             tx_valid;
	logic [2:0]             tx_ready;
	logic [2:0][7:0]        rx_data;
	logic [2:0]             rx_valid;
	logic [2:0]             rx_ready;
	logic [2:0]             line_tx;
	logic [2:0]             line_rx;
	logic [1:0]             cts_n;
	logic [1:0]             rts_n;
	upi_stat_type [2:0]     stat;
	logic                   hold;
	logic [2:0]             stb;
	logic [2:0][8:0]        frame;
	logic [31:0]            seed;
	logic [8:0]             q_tx[3][$];
	logic [7:0]             q_rx[3][$];
	int                     num_errors;
	int                     total_checks;

	upi_serial #(.BAUD_HALF(HALF)) DUT (.clk_sys_in(clk_sys_in),
		.srst_in(srst_in), .cfg_in(cfg), .tx_data_in(tx_data),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_data_out(rx_data), .rx_valid_out(rx_valid),
		.rx_ready_in(rx_ready), .serial_tx_out(line_tx),
		.serial_rx_in(line_rx), .clear_to_send_n_in(cts_n),
		.request_to_send_n_out(rts_n), .status_out(stat));

	upi_peer #(.BIT_CYC(32 * 2)) peer (.clk_sys_in(clk_sys_in),
		.serial_tx_in(line_tx), .hold_cts_in(hold),
		.serial_rx_out(line_rx), .clear_to_send_n_out(cts_n),
		.stb_out(stb), .frame_out(frame));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	////////////////////////////////////////////////////////////////////////
	// checking and reporting
	task automatic note(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_frame(input logic [8:0] g, input logic [8:0] e);
		note(g, e);
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		note({1'b0, g}, {1'b0, e});
	endtask
	task automatic chk_lvl(input logic [2:0] g, input logic [2:0] e);
		note({6'h00, g}, {6'h00, e});
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// results are compared at the falling edge, when they are settled
	always @(negedge clk_sys_in)
		for (int c = 0; c < 3; c++)
		begin
			// a result with nothing noted is held against its inverse
			if (stb[c] && q_tx[c].size() != 0)
				chk_frame(frame[c], q_tx[c].pop_front());
			else if (stb[c])
				chk_frame(frame[c], ~frame[c]);
			if (rx_valid[c] === 1'b1 && rx_ready[c] === 1'b1)
			begin
				if (q_rx[c].size() != 0)
					chk_byte(rx_data[c], q_rx[c].pop_front());
				else
					chk_byte(rx_data[c], ~rx_data[c]);
			end
		end

	////////////////////////////////////////////////////////////////////////
	// stimulus helpers
	task automatic push(input int c);
		logic [7:0] b;
		// private copy: parallel callers move the shared seed meanwhile
		seed = lfsr(seed);
		b = seed[7:0];
		@(posedge clk_sys_in);
		tx_data[c] <= b;
		tx_valid[c] <= 1'b1;
		q_tx[c].push_back({1'b1, b});
		do @(negedge clk_sys_in); while (tx_ready[c] !== 1'b1);
		@(posedge clk_sys_in);
		tx_valid[c] <= 1'b0;
	endtask

	task automatic feed(input int c);
		seed = lfsr(seed);
		q_rx[c].push_back(seed[7:0]);
		peer.send(c, seed[7:0], 1'b1);
	endtask

	task automatic drain();
		int n;
		for (int i = 0; i < 5000; i++)
		begin
			n = 0;
			for (int c = 0; c < 3; c++)
				n += q_tx[c].size() + q_rx[c].size();
			if (n == 0)
				return;
			@(posedge clk_sys_in);
		end
		num_errors++;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_sys_in);
		num_errors++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		num_errors = 0;
		total_checks = 0;
		seed = 32'h753C8D38;
		srst_in = 1'b1;
		hold = 1'b0;
		tx_data = '0;
		tx_valid = 3'h0;
		rx_ready = 3'h7;
		for (int c = 0; c < 3; c++)
			cfg[c] = '{tx_en: 1'b1, rx_en: 1'b1, default: 1'b0};
		repeat (5) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		@(negedge clk_sys_in);
		chk_lvl(line_tx, 3'h7);
		chk_lvl({1'b0, rts_n}, 3'h3);
		// all three channels send back to back
		fork
			begin push(0); push(0); end
			begin push(1); push(1); end
			begin push(2); push(2); end
		join
		drain();
		fork feed(0); feed(1); feed(2); join
		drain();
		// held clear-to-send fills the buffer and blocks the start
		hold <= 1'b1;
		cfg[0].cts_en <= 1'b1;
		push(0);
		push(0);
		repeat (300) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_lvl({2'h0, line_tx[0]}, 3'h1);
		chk_lvl({2'h0, tx_ready[0]}, 3'h0);
		chk_lvl({2'h0, rts_n[0]}, 3'h0);
		chk_lvl({2'h0, stat[0].tx_busy}, 3'h0);
		@(posedge clk_sys_in);
		hold <= 1'b0;
		drain();
		// receive fill level drives request-to-send while reader stalls;
		// a third word into the full buffer is lost and flags overrun
		cfg[1].rts_fifo_mode <= 1'b1;
		rx_ready[1] <= 1'b0;
		feed(1);
		feed(1);
		seed = lfsr(seed);
		peer.send(1, seed[7:0], 1'b1);
		repeat (10) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_lvl({2'h0, rts_n[1]}, 3'h1);
		chk_lvl({2'h0, stat[1].overrun}, 3'h1);
		@(posedge clk_sys_in);
		rx_ready[1] <= 1'b1;
		drain();
		@(negedge clk_sys_in);
		chk_lvl({2'h0, rts_n[1]}, 3'h0);
		// loopback keeps the pin at mark; any frame seen there is flagged
		@(posedge clk_sys_in);
		cfg[1].loopback <= 1'b1;
		q_rx[1].push_back(seed[15:8]);
		@(posedge clk_sys_in);
		tx_data[1] <= seed[15:8];
		tx_valid[1] <= 1'b1;
		@(posedge clk_sys_in);
		tx_valid[1] <= 1'b0;
		drain();
		// disabled transmitter holds mark; a low stop bit flags framing
		cfg[0].tx_en <= 1'b0;
		push(0);
		peer.send(0, 8'h3C, 1'b0);
		@(negedge clk_sys_in);
		chk_lvl({1'b0, line_tx[0], stat[0].tx_busy}, 3'h2);
		chk_lvl({2'h0, stat[0].frame_err}, 3'h1);
		@(posedge clk_sys_in);
		cfg[0].tx_en <= 1'b1;
		drain();
		// stopped clock restarts on a receive line change
		cfg[2].rx_en <= 1'b0;
		cfg[2].sleep_req <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_lvl({2'h0, stat[2].clk_running}, 3'h0);
		@(posedge clk_sys_in);
		fork peer.send(2, 8'h0F, 1'b1); join_none
		repeat (12) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_lvl({2'h0, stat[2].clk_running}, 3'h1);
		repeat (700) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk_lvl({stat[0].overrun, stat[1].frame_err, 1'b0}, 3'h0);
		summarize();
	end
endmodule

// *** tb/upi_peer.sv ***
// far-side serial peer: decodes frames, sends frames, grants clear-to-send
`timescale 1ns/100ps

module upi_peer #(parameter int BIT_CYC = 64)
(
	input  wire logic        clk_sys_in,
	input  wire logic [2:0]  serial_tx_in,
	input  wire logic        hold_cts_in,
	output logic [2:0]       serial_rx_out,
	output logic [1:0]       clear_to_send_n_out,
	output logic [2:0]       stb_out,
	output logic [2:0][8:0]  frame_out
);
	initial
	begin
		serial_rx_out = 3'h7;
		stb_out       = 3'h0;
		frame_out     = '0;
	end

	assign clear_to_send_n_out = hold_cts_in ? 2'h3 : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// sample mid-bit from the start edge; stop bit lands in frame bit 8
	for (genvar c = 0; c < 3; c++)
	begin : g_rx
		logic [8:0] sh;
		always
		begin
			@(negedge serial_tx_in[c]);
			repeat (BIT_CYC / 2) @(posedge clk_sys_in);
			for (int i = 0; i < 9; i++)
			begin
				repeat (BIT_CYC) @(posedge clk_sys_in);
				sh[i] = serial_tx_in[c];
			end
			frame_out[c] = sh;
			stb_out[c] = 1'b1;
			@(posedge clk_sys_in);
			stb_out[c] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start low, data lsb first, one stop high, line rests at mark
	// stp low sends a broken stop bit; mark is restored a bit time later
	task automatic send(input int c, input logic [7:0] b,
		input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			serial_rx_out[c] <= f[i];
			repeat (BIT_CYC) @(posedge clk_sys_in);
		end
		if (!stp)
		begin
			serial_rx_out[c] <= 1'b1;
			repeat (BIT_CYC) @(posedge clk_sys_in);
		end
	endtask
endmodule
